// [rtl/gptu_regs.vh]
// Register map, field positions and reset values of the timer unit
`ifndef GPTU_REGS_VH
`define GPTU_REGS_VH
`define GPTU_A_CTL_A    12'h000
`define GPTU_A_CTL_CORE 12'h004
`define GPTU_A_CTL_B    12'h008
`define GPTU_A_CTL_S5   12'h00C
`define GPTU_A_CTL_S6   12'h010
`define GPTU_A_CNT_A    12'h014
`define GPTU_A_CNT_CORE 12'h018
`define GPTU_A_CNT_B    12'h01C
`define GPTU_A_CNT_S5   12'h020
`define GPTU_A_CNT_S6   12'h024
`define GPTU_A_CAPTURE_RELOAD_REGISTER   12'h028
`define GPTU_A_FLAGS    12'h02C
`define GPTU_A_PINS     12'h030
// Control word fields
`define GPTU_F_PRE      2:0
`define GPTU_F_MODE     5:3
`define GPTU_F_RUN      6
`define GPTU_F_DIR      7
`define GPTU_F_EUD      8
`define GPTU_F_EDGE     10:9
`define GPTU_F_RISE     9
`define GPTU_F_FALL     10
`define GPTU_F_OE       11
`define GPTU_F_CLR      12
`define GPTU_F_TLSEL    13
// Mode codes
`define GPTU_M_TIMER    3'h0
`define GPTU_M_COUNTER  3'h1
`define GPTU_M_GATE_LO  3'h2
`define GPTU_M_GATE_HI  3'h3
`define GPTU_M_RELOAD   3'h4
`define GPTU_M_CAPTURE  3'h5
`define GPTU_CTL_RST    16'h0000
`define GPTU_CNT_RST    16'h0000
`define GPTU_M1_SHIFT   3
`define GPTU_M2_SHIFT   2
`endif

// [rtl/gptu_top.v]
// Five-timer general purpose timer unit with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "gptu_regs.vh"
module gptu_top #(
    parameter W = 16
) (
    input  wire          clk,
    input  wire          rst,
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [11:0]   paddr,
    input  wire [31:0]   pwdata,
    output reg  [31:0]   prdata,
    output reg           pready,
    output reg           pslverr,
    input  wire [4:0]    timer_gate_clock_input,
    input  wire [4:0]    external_direction_input,
    input  wire          capture_input_pin,
    output reg           toggle_output_pin,
    output reg           second_toggle_output_pin,
    output reg           compare_unit_clock
);
// Timer index: 0 aux_a, 1 core, 2 aux_b, 3 second_aux, 4 second_core
////////////////////////////////////////////////////////////////////////
reg  [15:0]  ctl_r [0:4];
reg  [W-1:0] cnt_r [0:4];
reg  [W-1:0] capture_reload_register_r;
reg  [5:0]   flag_r;
reg  [9:0]   pre_r;
reg  [9:0]   pre_prev_r;
reg          core_tl_r;
reg          core_tl_d_r;
reg          sec_tl_r;
reg          sec_tl_d_r;
wire [5:0]   pin_lvl;
wire [5:0]   pin_prev;
wire [4:0]   eud_lvl;
// Access phase that has not been answered yet
wire         acc_now = psel & penable & ~pready;
wire         wr_acc  = acc_now & pwrite;
////////////////////////////////////////////////////////////////////////
// Pin synchronisers: bits 0..4 timer pins, 5 capture pin
genvar g;
generate
    for (g = 0; g < 6; g = g + 1) begin : g_sync
        wire      raw;
        reg [2:0] sync_r;
        reg       lvl_r;
        reg       lvl_d_r;
        if (g < 5) begin : g_timer
            assign raw = timer_gate_clock_input[g];
        end else begin : g_capture
            assign raw = capture_input_pin;
        end
        // Only the second stage reads the possibly metastable first one
        always @(posedge clk) begin
            if (rst) begin
                sync_r  <= 3'h0;
                lvl_r   <= 1'b0;
                lvl_d_r <= 1'b0;
            end else begin
                sync_r <= {sync_r[1:0], raw};
                // Level counts once second and third stages agree
                if (sync_r[1] == sync_r[2]) begin
                    lvl_r <= sync_r[2];
                end
                lvl_d_r <= lvl_r;
            end
        end
        assign pin_lvl[g]  = lvl_r;
        assign pin_prev[g] = lvl_d_r;
    end
endgenerate
// Direction pins pass the same three stages and agree filter
generate
    for (g = 0; g < 5; g = g + 1) begin : g_dir
        reg [2:0] sync_r;
        reg       lvl_r;
        always @(posedge clk) begin
            if (rst) begin
                sync_r <= 3'h0;
                lvl_r  <= 1'b0;
            end else begin
                sync_r <= {sync_r[1:0], external_direction_input[g]};
                if (sync_r[1] == sync_r[2]) begin
                    lvl_r <= sync_r[2];
                end
            end
        end
        assign eud_lvl[g] = lvl_r;
    end
endgenerate
////////////////////////////////////////////////////////////////////////
// Free-running prescaler; a tap rising edge is one tick
// Never cleared on enable, so the first tick may come up to a period early
localparam M1_TAP = `GPTU_M1_SHIFT - 1;
localparam M2_TAP = `GPTU_M2_SHIFT - 1;
always @(posedge clk) begin
    if (rst) begin
        pre_r      <= 10'h000;
        pre_prev_r <= 10'h000;
    end else begin
        pre_r      <= pre_r + 10'h001;
        pre_prev_r <= pre_r;
    end
end
wire [9:0] pre_tick = pre_r & ~pre_prev_r;
////////////////////////////////////////////////////////////////////////
// Edge select: 01 rising, 10 falling, 11 both
function edge_hit;
    input [1:0] sel;
    input       now;
    input       was;
    begin
        edge_hit = (sel[0] & now & ~was) | (sel[1] & ~now & was);
    end
endfunction
wire core_tl_rise = core_tl_r & ~core_tl_d_r;
wire core_tl_fall = ~core_tl_r & core_tl_d_r;
wire sec_tl_edge  = sec_tl_r ^ sec_tl_d_r;
// Per-timer advance and direction
reg  [4:0] tick;
reg  [4:0] down;
reg  [4:0] stop;
integer i;
always @* begin
    for (i = 0; i < 5; i = i + 1) begin
        if (i < 3) begin
            tick[i] = pre_tick[ctl_r[i][`GPTU_F_PRE] + M1_TAP];
        end else begin
            tick[i] = pre_tick[ctl_r[i][`GPTU_F_PRE] + M2_TAP];
        end
        stop[i] = 1'b0;
        case (ctl_r[i][`GPTU_F_MODE])
            `GPTU_M_COUNTER: begin
                if ((i == 0 || i == 2) && ctl_r[i][`GPTU_F_TLSEL]) begin
                    tick[i] = edge_hit(ctl_r[i][`GPTU_F_EDGE], core_tl_r, core_tl_d_r);
                end else if (i == 3 && ctl_r[i][`GPTU_F_TLSEL]) begin
                    tick[i] = sec_tl_edge;
                end else begin
                    tick[i] = edge_hit(ctl_r[i][`GPTU_F_EDGE], pin_lvl[i], pin_prev[i]);
                end
            end
            `GPTU_M_GATE_LO: tick[i] = tick[i] & ~pin_lvl[i];
            `GPTU_M_GATE_HI: tick[i] = tick[i] & pin_lvl[i];
            `GPTU_M_RELOAD,
            `GPTU_M_CAPTURE: stop[i] = (i == 0 || i == 2);
            default: tick[i] = tick[i];
        endcase
        tick[i] = tick[i] & ctl_r[i][`GPTU_F_RUN] & ~stop[i];
        if (ctl_r[i][`GPTU_F_EUD]) begin
            down[i] = ctl_r[i][`GPTU_F_DIR] ^ eud_lvl[i];
        end else begin
            down[i] = ctl_r[i][`GPTU_F_DIR];
        end
    end
end
wire [4:0]   wrap;
wire [W-1:0] cnt_step [0:4];
generate
    for (g = 0; g < 5; g = g + 1) begin : g_wrap
        assign wrap[g] = tick[g] & (down[g] ? (cnt_r[g] == {W{1'b0}})
                                            : (cnt_r[g] == {W{1'b1}}));
        assign cnt_step[g] = down[g] ? cnt_r[g] - {{(W-1){1'b0}}, 1'b1}
                                     : cnt_r[g] + {{(W-1){1'b0}}, 1'b1};
    end
endgenerate
////////////////////////////////////////////////////////////////////////
// Capture and reload triggers
// aux capture on own pin
wire cap_a = (ctl_r[0][`GPTU_F_MODE] == `GPTU_M_CAPTURE) &
             edge_hit(ctl_r[0][`GPTU_F_EDGE], pin_lvl[0], pin_prev[0]);
wire cap_b = (ctl_r[2][`GPTU_F_MODE] == `GPTU_M_CAPTURE) &
             edge_hit(ctl_r[2][`GPTU_F_EDGE], pin_lvl[2], pin_prev[2]);
// reload on pin or latch edge; TLSEL picks latch, edge bits pick direction
wire rl_a = (ctl_r[0][`GPTU_F_MODE] == `GPTU_M_RELOAD) &
            (ctl_r[0][`GPTU_F_TLSEL] ?
             ((ctl_r[0][`GPTU_F_RISE] & core_tl_rise) |
              (ctl_r[0][`GPTU_F_FALL] & core_tl_fall)) :
             edge_hit(ctl_r[0][`GPTU_F_EDGE], pin_lvl[0], pin_prev[0]));
wire rl_b = (ctl_r[2][`GPTU_F_MODE] == `GPTU_M_RELOAD) &
            (ctl_r[2][`GPTU_F_TLSEL] ?
             ((ctl_r[2][`GPTU_F_RISE] & core_tl_rise) |
              (ctl_r[2][`GPTU_F_FALL] & core_tl_fall)) :
             edge_hit(ctl_r[2][`GPTU_F_EDGE], pin_lvl[2], pin_prev[2]));
wire cap_sec = edge_hit(ctl_r[3][`GPTU_F_EDGE], pin_lvl[5], pin_prev[5]);
// sticky flags: set wins over write-one-to-clear
wire [5:0] flag_clr = (wr_acc && paddr == `GPTU_A_FLAGS) ? pwdata[5:0] : 6'h00;
wire [5:0] flag_set = {cap_sec, wrap[4], wrap[3], wrap[2] | cap_b, wrap[1], wrap[0] | cap_a};
////////////////////////////////////////////////////////////////////////
// Counters, latches and flags
integer k;
always @(posedge clk) begin
    if (rst) begin
        for (k = 0; k < 5; k = k + 1) begin
            ctl_r[k] <= `GPTU_CTL_RST;
            cnt_r[k] <= `GPTU_CNT_RST;
        end
        capture_reload_register_r    <= `GPTU_CNT_RST;
        flag_r      <= 6'h00;
    end else begin
        for (k = 0; k < 5; k = k + 1) begin
            if (tick[k]) begin
                cnt_r[k] <= cnt_step[k];
            end
        end
        if (cap_a) begin
            cnt_r[0] <= cnt_r[1];
        end
        if (cap_b) begin
            cnt_r[2] <= cnt_r[1];
        end
        // reload core; both on one latch edge is a setup error, A wins
        if (rl_a) begin
            cnt_r[1] <= cnt_r[0];
        end else if (rl_b) begin
            cnt_r[1] <= cnt_r[2];
        end
        if (wrap[4]) begin
            cnt_r[4] <= capture_reload_register_r;
        end
        if (cap_sec) begin
            capture_reload_register_r <= cnt_r[3];
            // optional clear, wins over a tick in the same cycle
            if (ctl_r[3][`GPTU_F_CLR]) begin
                cnt_r[3] <= {W{1'b0}};
            end
        end
        // Bus writes; hardware updates in the same cycle would lose to them
        if (wr_acc) begin
            case (paddr)
                `GPTU_A_CTL_A:    ctl_r[0] <= pwdata[15:0];
                `GPTU_A_CTL_CORE: ctl_r[1] <= pwdata[15:0];
                `GPTU_A_CTL_B:    ctl_r[2] <= pwdata[15:0];
                `GPTU_A_CTL_S5:   ctl_r[3] <= pwdata[15:0];
                `GPTU_A_CTL_S6:   ctl_r[4] <= pwdata[15:0];
                `GPTU_A_CNT_A:    cnt_r[0] <= pwdata[W-1:0];
                `GPTU_A_CNT_CORE: cnt_r[1] <= pwdata[W-1:0];
                `GPTU_A_CNT_B:    cnt_r[2] <= pwdata[W-1:0];
                `GPTU_A_CNT_S5:   cnt_r[3] <= pwdata[W-1:0];
                `GPTU_A_CNT_S6:   cnt_r[4] <= pwdata[W-1:0];
                `GPTU_A_CAPTURE_RELOAD_REGISTER:   capture_reload_register_r <= pwdata[W-1:0];
                default: ;
            endcase
        end
        flag_r <= (flag_r & ~flag_clr) | flag_set;
    end
end
// Toggle latches and their output pins
always @(posedge clk) begin
    if (rst) begin
        core_tl_r   <= 1'b0;
        core_tl_d_r <= 1'b0;
        sec_tl_r    <= 1'b0;
        sec_tl_d_r  <= 1'b0;
        toggle_output_pin        <= 1'b0;
        second_toggle_output_pin <= 1'b0;
        compare_unit_clock       <= 1'b0;
    end else begin
        if (wrap[1]) begin
            core_tl_r <= ~core_tl_r;
        end
        if (wrap[4]) begin
            sec_tl_r <= ~sec_tl_r;
        end
        core_tl_d_r <= core_tl_r;
        sec_tl_d_r  <= sec_tl_r;
        toggle_output_pin        <= core_tl_r & ctl_r[1][`GPTU_F_OE];
        second_toggle_output_pin <= sec_tl_r & ctl_r[4][`GPTU_F_OE];
        compare_unit_clock <= wrap[4];
    end
end
////////////////////////////////////////////////////////////////////////
// APB slave: one wait state, error on unmapped address
reg [31:0] rd_nxt;
reg        hit_nxt;
always @* begin
    hit_nxt = 1'b1;
    rd_nxt  = 32'h0000_0000;
    case (paddr)
        `GPTU_A_CTL_A:    rd_nxt[15:0] = ctl_r[0];
        `GPTU_A_CTL_CORE: rd_nxt[15:0] = ctl_r[1];
        `GPTU_A_CTL_B:    rd_nxt[15:0] = ctl_r[2];
        `GPTU_A_CTL_S5:   rd_nxt[15:0] = ctl_r[3];
        `GPTU_A_CTL_S6:   rd_nxt[15:0] = ctl_r[4];
        `GPTU_A_CNT_A:    rd_nxt[W-1:0] = cnt_r[0];
        `GPTU_A_CNT_CORE: rd_nxt[W-1:0] = cnt_r[1];
        `GPTU_A_CNT_B:    rd_nxt[W-1:0] = cnt_r[2];
        `GPTU_A_CNT_S5:   rd_nxt[W-1:0] = cnt_r[3];
        `GPTU_A_CNT_S6:   rd_nxt[W-1:0] = cnt_r[4];
        `GPTU_A_CAPTURE_RELOAD_REGISTER:   rd_nxt[W-1:0] = capture_reload_register_r;
        `GPTU_A_FLAGS:    rd_nxt[5:0] = flag_r;
        `GPTU_A_PINS:     rd_nxt[1:0] = {sec_tl_r, core_tl_r};
        default:          hit_nxt = 1'b0;
    endcase
end
always @(posedge clk) begin
    if (rst) begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
    end else if (acc_now) begin
        // Registered answer keeps outputs clean at the cost of one wait state
        pready  <= 1'b1;
        pslverr <= ~hit_nxt;
        prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
    end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
    end
end
endmodule
`default_nettype wire

// [tb/gptu_assertions.sv]
// Bus handshake and output pulse checks for the timer unit
`timescale 1ns/1ps
`default_nettype none
module gptu_chk (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        toggle_output_pin,
    input wire logic        second_toggle_output_pin,
    input wire logic        compare_unit_clock
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Access phase still waiting for its answer
    wire logic acc = psel && penable && !pready;
    ////////////////////////////////////////////////////////////////////////
    property p_ans; acc |=> pready; endproperty
    a_ans: assert property (p_ans) else $error("access not answered");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("ready longer than one cycle");
    property p_idle; !(psel && penable) |=> !pready; endproperty
    a_idle: assert property (p_idle) else $error("ready without access");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_zero; !pready |-> prdata == 32'h0000_0000; endproperty
    a_zero: assert property (p_zero) else $error("read data outside answer");
    property p_unmap; acc && paddr > 12'h030 |=> pslverr; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped address accepted");
    property p_map; acc && paddr <= 12'h030 && paddr[1:0] == 2'b00 |=> !pslverr; endproperty
    a_map: assert property (p_map) else $error("mapped address refused");
    property p_cuc; compare_unit_clock |=> !compare_unit_clock; endproperty
    a_cuc: assert property (p_cuc) else $error("wrap pulse too long");
    property p_rst;
        $fell(rst) |-> !pready && !toggle_output_pin && !second_toggle_output_pin;
    endproperty
    a_rst: assert property (p_rst) else $error("output high after reset");
    c_err: cover property (pslverr);
    c_cuc: cover property (compare_unit_clock);
    c_tog: cover property ($rose(toggle_output_pin));
endmodule
bind gptu_top gptu_chk u_chk (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .toggle_output_pin(toggle_output_pin), .compare_unit_clock(compare_unit_clock),
    .second_toggle_output_pin(second_toggle_output_pin)
);
`default_nettype wire

// [tb/gptu_pins.sv]
// Model of the gate, clock, direction and capture pins outside the unit
`timescale 1ns/1ps
`default_nettype none
module gptu_pins (
    input  wire logic       clk,
    output var  logic [4:0] gate,
    output var  logic [4:0] dir,
    output var  logic       cap
);
    initial begin
        gate = 5'h00;
        dir = 5'h00;
        cap = 1'b0;
    end
    task automatic set_lv(input logic [4:0] g, input logic [4:0] d);
        @(posedge clk);
        gate <= g;
        dir <= d;
    endtask
    // Phases of 8 cycles outlast the unit's pin synchroniser and filter
    task automatic pulse(input int i, input int n);
        repeat (n) begin
            @(posedge clk);
            if (i == 5) cap <= 1'b1;
            else gate[i] <= 1'b1;
            repeat (8) @(posedge clk);
            if (i == 5) cap <= 1'b0;
            else gate[i] <= 1'b0;
            repeat (8) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// [tb/gptu_top_bench.sv]
// Self-checking bench for the timer unit
`timescale 1ns/1ps
`default_nettype none
`include "gptu_regs.vh"
module gptu_top_bench;
    typedef struct packed {
        logic [2:0]  idx;
        logic [15:0] ctl;
        logic [4:0]  gate;
        logic [4:0]  dir;
        logic [11:0] cyc;
        logic [15:0] exp;
    } gptu_row_t;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire  [4:0]  gate;
    wire  [4:0]  dir;
    wire         cap;
    wire         tog;
    wire         tog2;
    wire         cuc;
    logic [31:0] rd;
    logic        er;
    logic [11:0] ca;
    int          n_fail = 0;
    int          compares = 0;
    int          n;
    gptu_row_t   rows [0:9];
    always #50 clk = ~clk;
    gptu_top dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_gate_clock_input(gate), .external_direction_input(dir),
        .capture_input_pin(cap), .toggle_output_pin(tog),
        .second_toggle_output_pin(tog2), .compare_unit_clock(cuc));
    gptu_pins pins (.clk(clk), .gate(gate), .dir(dir), .cap(cap));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            n_fail++;
            $display("[ERR] %0t: got %h want %h", $time, seen, want);
        end
    endtask
    // Prescaler phase is free running, so one tick either way is allowed
    task automatic near(input logic [31:0] seen, input logic [15:0] want);
        logic [15:0] d;
        d = seen[15:0] - want;
        chk(32'(d == 16'h0000 || d == 16'h0001 || d == 16'hFFFF), 32'h0000_0001);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) chk(32'h0000_0000, 32'h0000_0001);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] want);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, want);
    endtask
    task automatic results;
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // About four times the expected run length
    initial begin
        #(20000 * 100);
        n_fail++;
        results;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rows[0] = '{3'd1, 16'h0040, 5'h00, 5'h00, 12'd160, 16'h0014};
        rows[1] = '{3'd1, 16'h0047, 5'h00, 5'h00, 12'd2048, 16'h0002};
        rows[2] = '{3'd4, 16'h0040, 5'h00, 5'h00, 12'd80, 16'h0014};
        rows[3] = '{3'd3, 16'h0047, 5'h00, 5'h00, 12'd1024, 16'h0002};
        rows[4] = '{3'd0, 16'h00C0, 5'h00, 5'h00, 12'd80, 16'hFFF6};
        rows[5] = '{3'd2, 16'h0140, 5'h00, 5'h04, 12'd80, 16'hFFF6};
        rows[6] = '{3'd3, 16'h0140, 5'h00, 5'h08, 12'd40, 16'hFFF6};
        rows[7] = '{3'd1, 16'h0058, 5'h00, 5'h00, 12'd160, 16'h0000};
        rows[8] = '{3'd1, 16'h0058, 5'h02, 5'h00, 12'd160, 16'h0014};
        rows[9] = '{3'd0, 16'h0050, 5'h01, 5'h00, 12'd160, 16'h0000};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rdc(`GPTU_A_CTL_CORE, 32'h0000_0000);
        rdc(`GPTU_A_FLAGS, 32'h0000_0000);
        apb(1'b0, 12'h040, 32'h0000_0000);
        chk({rd[31:1], er}, 32'h0000_0001);
        $display("test reset and unmapped done");
        foreach (rows[i]) begin
            ca = 12'(rows[i].idx) * 12'h004;
            pins.set_lv(rows[i].gate, rows[i].dir);
            wr(ca + 12'h014, 32'h0000_0000);
            wr(ca, 32'(rows[i].ctl));
            repeat (int'(rows[i].cyc)) @(posedge clk);
            apb(1'b0, ca + 12'h014, 32'h0000_0000);
            near(rd, rows[i].exp);
            wr(ca, 32'h0000_0000);
        end
        pins.set_lv(5'h00, 5'h00);
        rdc(`GPTU_A_FLAGS, 32'h0000_000D);
        wr(`GPTU_A_FLAGS, 32'h0000_003F);
        rdc(`GPTU_A_FLAGS, 32'h0000_0000);
        $display("test rows done");
        wr(`GPTU_A_CNT_CORE, 32'h0000_0000);
        wr(`GPTU_A_CTL_CORE, 32'h0000_0248);
        pins.pulse(1, 5);
        rdc(`GPTU_A_CNT_CORE, 32'h0000_0005);
        wr(`GPTU_A_CTL_CORE, 32'h0000_0000);
        wr(`GPTU_A_CNT_CORE, 32'h0000_0ABC);
        wr(`GPTU_A_CNT_A, 32'h0000_0077);
        wr(`GPTU_A_CTL_A, 32'h0000_0268);
        repeat (40) @(posedge clk);
        rdc(`GPTU_A_CNT_A, 32'h0000_0077);
        pins.pulse(0, 1);
        rdc(`GPTU_A_CNT_A, 32'h0000_0ABC);
        wr(`GPTU_A_CTL_A, 32'h0000_0000);
        wr(`GPTU_A_CNT_B, 32'h0000_0321);
        wr(`GPTU_A_CTL_B, 32'h0000_0260);
        pins.pulse(2, 1);
        rdc(`GPTU_A_CNT_CORE, 32'h0000_0321);
        wr(`GPTU_A_CTL_B, 32'h0000_0000);
        wr(`GPTU_A_CNT_A, 32'h0000_0000);
        wr(`GPTU_A_CTL_A, 32'h0000_2248);
        wr(`GPTU_A_CNT_CORE, 32'h0000_FFFE);
        wr(`GPTU_A_CTL_CORE, 32'h0000_0840);
        repeat (30) @(posedge clk);
        chk(32'(tog), 32'h0000_0001);
        rdc(`GPTU_A_CNT_A, 32'h0000_0001);
        wr(`GPTU_A_CTL_A, 32'h0000_0000);
        wr(`GPTU_A_CTL_CORE, 32'h0000_0000);
        $display("test first module done");
        wr(`GPTU_A_CNT_S5, 32'h0000_0055);
        wr(`GPTU_A_CTL_S5, 32'h0000_1200);
        pins.pulse(5, 1);
        rdc(`GPTU_A_CAPTURE_RELOAD_REGISTER, 32'h0000_0055);
        rdc(`GPTU_A_CNT_S5, 32'h0000_0000);
        wr(`GPTU_A_CTL_S5, 32'h0000_2048);
        wr(`GPTU_A_CNT_S6, 32'h0000_FFFE);
        wr(`GPTU_A_CTL_S6, 32'h0000_0847);
        n = 0;
        while (cuc !== 1'b1 && n < 3000) begin
            n++;
            @(posedge clk);
        end
        chk(32'(n < 3000), 32'h0000_0001);
        repeat (3) @(posedge clk);
        chk(32'(tog2), 32'h0000_0001);
        rdc(`GPTU_A_CNT_S5, 32'h0000_0001);
        apb(1'b0, `GPTU_A_CNT_S6, 32'h0000_0000);
        near(rd, 16'h0055);
        rdc(`GPTU_A_PINS, 32'h0000_0003);
        $display("test second module done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chk(32'({tog, tog2, cuc}), 32'h0000_0000);
        rdc(`GPTU_A_CTL_S6, 32'h0000_0000);
        rdc(`GPTU_A_PINS, 32'h0000_0000);
        $display("test mid-run reset done");
        results;
    end
endmodule
`default_nettype wire
